/* rtl/mft_pkg.sv */
// Constants, field layouts and encodings of the multifunction timer.
// Assumes an 8-bit processor bus with 16-bit byte addresses.
package mft_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_CTRL_ONE = 16'h0236;
  localparam logic [15:0] ADDR_CTRL_TWO = 16'h0237;
  localparam logic [15:0] ADDR_CTRL_THREE = 16'h0238;
  localparam logic [15:0] ADDR_PRESC_LO = 16'h0239;
  localparam logic [15:0] ADDR_PRESC_HI = 16'h023A;
  localparam logic [15:0] ADDR_ACCU_LO = 16'h023C;
  localparam logic [15:0] ADDR_ACCU_HI = 16'h023D;
  localparam logic [15:0] ADDR_ADDEND_LO = 16'h023E;
  localparam logic [15:0] ADDR_ADDEND_HI = 16'h023F;

  // Control one fields
  localparam int C1_SER_LEVEL = 7;
  localparam int C1_CLK_HI = 6;
  localparam int C1_CLK_LO = 5;
  localparam int C1_STOP = 4;
  localparam int C1_START_HI = 3;
  localparam int C1_START_LO = 2;
  localparam int C1_HALF_LOAD = 1;
  localparam int C1_EDGE = 0;
  // Control two fields
  localparam int C2_PIN_HI = 7;
  localparam int C2_PIN_LO = 6;
  localparam int C2_LATCH_HI = 5;
  localparam int C2_LATCH_LO = 3;
  localparam int C2_ACLK_HI = 2;
  localparam int C2_ACLK_LO = 1;
  localparam int C2_CHAIN = 0;
  // Control three fields
  localparam int C3_IRQ_HI = 7;
  localparam int C3_IRQ_LO = 5;
  localparam int C3_LOAD_HI = 4;
  localparam int C3_LOAD_LO = 3;
  localparam int C3_LO_M1 = 2;
  localparam int C3_HI_M1 = 1;
  localparam int C3_SERIAL = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] MINUS_ONE = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MFT_CLK_PIN = 2'b00, MFT_CLK_OSC = 2'b01, MFT_CLK_PHI = 2'b10, MFT_CLK_NONE = 2'b11
  } mft_clk_t;
  typedef enum logic [1:0] {
    MFT_ST_ALWAYS = 2'b00, MFT_ST_EDGE = 2'b01, MFT_ST_HIGH = 2'b10, MFT_ST_LOW = 2'b11
  } mft_start_t;
  typedef enum logic [1:0] {
    MFT_PO_OFF = 2'b00, MFT_PO_SERIAL = 2'b01, MFT_PO_PWM = 2'b10, MFT_PO_CARRY = 2'b11
  } mft_pinout_t;
  typedef enum logic [2:0] {
    MFT_RL_OFF = 3'b000, MFT_RL_CARRY_LO = 3'b001, MFT_RL_CARRY_HI = 3'b010,
    MFT_RL_PIN = 3'b011, MFT_RL_NPIN = 3'b100, MFT_RL_PRESC_OUT = 3'b101,
    MFT_RL_PRESC_IN = 3'b110
  } mft_latch_t;
  typedef enum logic [1:0] {
    MFT_AC_PRESC_IN = 2'b00, MFT_AC_PRESC_OUT = 2'b01, MFT_AC_PIN = 2'b10, MFT_AC_NPIN = 2'b11
  } mft_aclk_t;
  typedef enum logic [2:0] {
    MFT_IE_NONE = 3'b000, MFT_IE_PIN = 3'b001, MFT_IE_NPIN = 3'b010,
    MFT_IE_CARRY_LO = 3'b011, MFT_IE_CARRY_HI = 3'b100
  } mft_irq_t;
  typedef enum logic [1:0] {
    MFT_LD_NONE = 2'b00, MFT_LD_CARRY_LO = 2'b01, MFT_LD_CARRY_HI = 2'b10, MFT_LD_REG = 2'b11
  } mft_load_t;
endpackage

/* rtl/mft_pin_if.sv */
// Synchronised pin levels and edges passed from the pin synchroniser to the timer core.
// Assumes both ends run on the timer's single clock.
`timescale 1ns/1ps
interface mft_pin_if #(parameter int WIDTH = 2);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport sync (output level, output rise, output fall);
  modport core (input level, input rise, input fall);
endinterface

/* rtl/mft_pin_sync.sv */
// Three-stage synchroniser and edge detector for the timer's external pins.
// Assumes raw pins are asynchronous to ref_clk_in.
`timescale 1ns/1ps
module mft_pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Raw pins
  input wire logic [WIDTH-1:0] raw_in,
  // Clean side
  mft_pin_if.sync pins
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] agree;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else if (ce_in) begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Only a level seen by both later stages counts
      level_ff <= (agree & s3_ff) | (~agree & level_ff);
    end
  end

  assign agree = ~(s2_ff ^ s3_ff);
  // Edges are single-cycle strobes, valid only while ce_in is high
  assign pins.rise = {WIDTH{ce_in}} & agree & s3_ff & ~level_ff;
  assign pins.fall = {WIDTH{ce_in}} & agree & ~s3_ff & level_ff;
  assign pins.level = level_ff;
endmodule

/* rtl/mft_timer.sv */
// Multifunction 16-bit timer/counter with byte registers on the processor bus.
// Assumes osc and phase-two strobes are one-cycle pulses on ref_clk_in.
//
// Functional notes
// - Clock source: 00 pin, 01 oscillator, 10 phase-two clock, 11 none.
// - Counter stop bit set halts counting on accumulator carry out.
// - Start: 00 always, 01 after an edge, 10 pin high, 11 pin low.
// - Control one bit 1 enables half load of the accumulators.
// - Active edge bit: 0 rising, 1 falling.
// - Control one bit 7 enables the second serial input level.
// - Pin output: 00 off, 01 serial, 10 PWM, 11 high accumulator carry.
// - Read latch trigger: off, carries, pin, inverted pin, prescaler out or in.
// - Accumulator clock: prescaler input, prescaler output, pin, inverted pin.
// - Control two bit 0 chains both bytes into one 16-bit accumulator.
// - Interrupt event: none, pin, inverted pin, low carry, high carry.
// - Reload event: never, low carry, high carry; code 11 (register load) never reloads.
// - Low accumulator adds the adder register, or minus one when set.
// - High accumulator adds the adder register, or minus one when set.
// - Control three bit 0 enables serial mode.
// - Prescaler is a 16-bit write-only value, low then high byte.
// - Accumulator bytes are loadable by processor byte writes.
// - Adder register is written and read back as two bytes.
// - Interrupt request feeds interrupt controller source 2, prioritised elsewhere.
`timescale 1ns/1ps
module mft_timer (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Processor bus
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  // Clock strobes
  input wire logic osc_tick_in,
  input wire logic processor_phase_two_clock_in,
  // Pins
  input wire logic timer_pin_in,
  input wire logic serial_in_two_in,
  output logic timer_pin_out,
  output logic timer_pin_oe_out,
  // Status
  output logic irq_out,
  output logic running_out,
  output logic [15:0] capture_out
);
  mft_pin_if #(.WIDTH(2)) pins ();
  mft_pin_sync #(.WIDTH(2)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .raw_in({serial_in_two_in, timer_pin_in}),
    .pins(pins)
  );

  logic [7:0] ctrl1_ff, ctrl2_ff, ctrl3_ff;
  logic [15:0] presc_ld_ff, presc_cnt_ff, addend_ff, accu_ff;
  logic armed_ff, stopped_ff, carry_tgl_ff;
  logic pin_lvl, act_edge, other_edge, src_tick, run, presc_in, presc_out;
  logic step, carry_lo, carry_hi, reload, ser_bit, latch_ev, irq_ev, stop_ev, pin_nxt;
  logic [7:0] add_lo, add_hi;
  logic [8:0] sum_lo, sum_hi;

  function automatic logic wr_at(input logic [15:0] off);
    wr_at = bus_wr_in && (bus_addr_in == off);
  endfunction

  assign pin_lvl = pins.level[0];
  assign act_edge = ctrl1_ff[mft_pkg::C1_EDGE] ? pins.fall[0] : pins.rise[0];
  assign other_edge = ctrl1_ff[mft_pkg::C1_EDGE] ? pins.rise[0] : pins.fall[0];

  // Control and data registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl1_ff <= mft_pkg::CTRL_RESET;
      ctrl2_ff <= mft_pkg::CTRL_RESET;
      ctrl3_ff <= mft_pkg::CTRL_RESET;
      presc_ld_ff <= mft_pkg::WORD_RESET;
      addend_ff <= mft_pkg::WORD_RESET;
    end else if (ce_in) begin
      if (wr_at(mft_pkg::ADDR_CTRL_ONE)) ctrl1_ff <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_CTRL_TWO)) ctrl2_ff <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_CTRL_THREE)) ctrl3_ff <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_PRESC_LO)) presc_ld_ff[7:0] <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_PRESC_HI)) presc_ld_ff[15:8] <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_ADDEND_LO)) addend_ff[7:0] <= bus_wdata_in;
      if (wr_at(mft_pkg::ADDR_ADDEND_HI)) addend_ff[15:8] <= bus_wdata_in;
    end
  end

  // Read port: only the adder bytes hold defined data
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= mft_pkg::READ_ZERO;
    end else if (ce_in && bus_rd_in) begin
      case (bus_addr_in)
        mft_pkg::ADDR_ADDEND_LO: bus_rdata_out <= addend_ff[7:0];
        mft_pkg::ADDR_ADDEND_HI: bus_rdata_out <= addend_ff[15:8];
        default: bus_rdata_out <= mft_pkg::READ_ZERO;
      endcase
    end
  end

  // Timer clock and start gating
  always_comb begin
    case (mft_pkg::mft_clk_t'(ctrl1_ff[mft_pkg::C1_CLK_HI:mft_pkg::C1_CLK_LO]))
      mft_pkg::MFT_CLK_PIN: src_tick = act_edge;
      mft_pkg::MFT_CLK_OSC: src_tick = osc_tick_in;
      mft_pkg::MFT_CLK_PHI: src_tick = processor_phase_two_clock_in;
      default: src_tick = 1'b0;
    endcase
    case (mft_pkg::mft_start_t'(ctrl1_ff[mft_pkg::C1_START_HI:mft_pkg::C1_START_LO]))
      mft_pkg::MFT_ST_ALWAYS: run = !stopped_ff;
      mft_pkg::MFT_ST_EDGE: run = !stopped_ff && armed_ff;
      mft_pkg::MFT_ST_HIGH: run = !stopped_ff && pin_lvl;
      default: run = !stopped_ff && !pin_lvl;
    endcase
  end

  assign presc_in = ce_in && src_tick && run;
  assign presc_out = presc_in && (presc_cnt_ff == mft_pkg::WORD_RESET);

  // Armed after the chosen edge; a rewrite of control one disarms, edge wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_ff <= 1'b0;
    end else if (ce_in) begin
      if (act_edge) armed_ff <= 1'b1;
      else if (wr_at(mft_pkg::ADDR_CTRL_ONE)) armed_ff <= 1'b0;
    end
  end

  // Prescaler divides by value plus one
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_cnt_ff <= mft_pkg::WORD_RESET;
    end else if (presc_in) begin
      if (presc_out) presc_cnt_ff <= presc_ld_ff;
      else presc_cnt_ff <= presc_cnt_ff - 16'h0001;
    end
  end

  // Accumulator clock and adder
  always_comb begin
    case (mft_pkg::mft_aclk_t'(ctrl2_ff[mft_pkg::C2_ACLK_HI:mft_pkg::C2_ACLK_LO]))
      mft_pkg::MFT_AC_PRESC_IN: step = presc_in;
      mft_pkg::MFT_AC_PRESC_OUT: step = presc_out;
      mft_pkg::MFT_AC_PIN: step = run && act_edge;
      default: step = run && other_edge;
    endcase
  end

  assign add_lo = ctrl3_ff[mft_pkg::C3_LO_M1] ? mft_pkg::MINUS_ONE : addend_ff[7:0];
  assign add_hi = ctrl3_ff[mft_pkg::C3_HI_M1] ? mft_pkg::MINUS_ONE : addend_ff[15:8];
  assign sum_lo = {1'b0, accu_ff[7:0]} + {1'b0, add_lo};
  // Chaining passes the low carry into the high byte
  assign sum_hi = {1'b0, accu_ff[15:8]} + {1'b0, add_hi} +
                  {8'h00, ctrl2_ff[mft_pkg::C2_CHAIN] & sum_lo[8]};
  assign carry_lo = step && sum_lo[8] && !ctrl3_ff[mft_pkg::C3_SERIAL];
  assign carry_hi = step && sum_hi[8] && !ctrl3_ff[mft_pkg::C3_SERIAL];
  assign ser_bit = ctrl1_ff[mft_pkg::C1_SER_LEVEL] ? pins.level[1] : pin_lvl;
  assign stop_ev = ctrl2_ff[mft_pkg::C2_CHAIN] ? carry_hi : carry_lo;

  always_comb begin
    case (mft_pkg::mft_load_t'(ctrl3_ff[mft_pkg::C3_LOAD_HI:mft_pkg::C3_LOAD_LO]))
      mft_pkg::MFT_LD_CARRY_LO: reload = carry_lo;
      mft_pkg::MFT_LD_CARRY_HI: reload = carry_hi;
      default: reload = 1'b0;
    endcase
  end

  // Accumulator; bus writes win over counting
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accu_ff <= mft_pkg::WORD_RESET;
    end else if (ce_in) begin
      if (wr_at(mft_pkg::ADDR_ACCU_LO) || wr_at(mft_pkg::ADDR_ACCU_HI)) begin
        if (wr_at(mft_pkg::ADDR_ACCU_LO)) accu_ff[7:0] <= bus_wdata_in;
        if (wr_at(mft_pkg::ADDR_ACCU_HI)) accu_ff[15:8] <= bus_wdata_in;
      end else if (step && ctrl3_ff[mft_pkg::C3_SERIAL]) begin
        accu_ff[7:0] <= {accu_ff[6:0], ser_bit};
      end else if (reload) begin
        accu_ff[7:0] <= addend_ff[7:0];
        // Half load keeps the high byte counting
        if (ctrl1_ff[mft_pkg::C1_HALF_LOAD]) accu_ff[15:8] <= sum_hi[7:0];
        else accu_ff[15:8] <= addend_ff[15:8];
      end else if (step) begin
        accu_ff <= {sum_hi[7:0], sum_lo[7:0]};
      end
    end
  end

  // Stop on carry; set wins over the clearing rewrite
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stopped_ff <= 1'b0;
    end else if (ce_in) begin
      if (ctrl1_ff[mft_pkg::C1_STOP] && stop_ev) stopped_ff <= 1'b1;
      else if (wr_at(mft_pkg::ADDR_CTRL_ONE)) stopped_ff <= 1'b0;
    end
  end

  // Capture and interrupt event selection
  always_comb begin
    case (mft_pkg::mft_latch_t'(ctrl2_ff[mft_pkg::C2_LATCH_HI:mft_pkg::C2_LATCH_LO]))
      mft_pkg::MFT_RL_CARRY_LO: latch_ev = carry_lo;
      mft_pkg::MFT_RL_CARRY_HI: latch_ev = carry_hi;
      mft_pkg::MFT_RL_PIN: latch_ev = pins.rise[0];
      mft_pkg::MFT_RL_NPIN: latch_ev = pins.fall[0];
      mft_pkg::MFT_RL_PRESC_OUT: latch_ev = presc_out;
      mft_pkg::MFT_RL_PRESC_IN: latch_ev = presc_in;
      default: latch_ev = 1'b0;
    endcase
    case (mft_pkg::mft_irq_t'(ctrl3_ff[mft_pkg::C3_IRQ_HI:mft_pkg::C3_IRQ_LO]))
      mft_pkg::MFT_IE_PIN: irq_ev = pins.rise[0];
      mft_pkg::MFT_IE_NPIN: irq_ev = pins.fall[0];
      mft_pkg::MFT_IE_CARRY_LO: irq_ev = carry_lo;
      mft_pkg::MFT_IE_CARRY_HI: irq_ev = carry_hi;
      default: irq_ev = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_out <= mft_pkg::WORD_RESET;
    end else if (ce_in && latch_ev) begin
      capture_out <= accu_ff;
    end
  end

  // Strobe to interrupt controller source 2
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) irq_out <= 1'b0;
    else if (ce_in) irq_out <= irq_ev;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) running_out <= 1'b0;
    else if (ce_in) running_out <= run;
  end

  // Pin output
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) carry_tgl_ff <= 1'b0;
    else if (ce_in && carry_hi) carry_tgl_ff <= !carry_tgl_ff;
  end

  always_comb begin
    case (mft_pkg::mft_pinout_t'(ctrl2_ff[mft_pkg::C2_PIN_HI:mft_pkg::C2_PIN_LO]))
      mft_pkg::MFT_PO_SERIAL: pin_nxt = accu_ff[7];
      mft_pkg::MFT_PO_PWM: pin_nxt = accu_ff[15:8] < addend_ff[15:8];
      mft_pkg::MFT_PO_CARRY: pin_nxt = carry_tgl_ff;
      default: pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_pin_out <= 1'b0;
      timer_pin_oe_out <= 1'b0;
    end else if (ce_in) begin
      timer_pin_out <= pin_nxt;
      timer_pin_oe_out <= ctrl2_ff[mft_pkg::C2_PIN_HI:mft_pkg::C2_PIN_LO] != 2'b00;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_addend_lo_wr;
    ce_in && wr_at(mft_pkg::ADDR_ADDEND_LO) && !wr_at(mft_pkg::ADDR_ADDEND_HI);
  endsequence
  sequence s_read_lo;
    ce_in && !bus_wr_in && bus_rd_in && bus_addr_in == mft_pkg::ADDR_ADDEND_LO;
  endsequence
  // Read straight after the write, or after one cycle with no low-byte write
  property p_readback;
    logic [7:0] d;
    (s_addend_lo_wr, d = bus_wdata_in) ##1
      (s_read_lo or (!wr_at(mft_pkg::ADDR_ADDEND_LO) ##1 s_read_lo))
      |=> bus_rdata_out == d;
  endproperty
  a_readback: assert property (p_readback) else $error("adder readback wrong");

  property p_no_clock;
    ctrl1_ff[mft_pkg::C1_CLK_HI:mft_pkg::C1_CLK_LO] == 2'b11 |-> !presc_in;
  endproperty
  a_no_clock: assert property (p_no_clock) else $error("prescaler ran with no clock");

  property p_stop;
    ce_in && ctrl1_ff[mft_pkg::C1_STOP] && stop_ev && !wr_at(mft_pkg::ADDR_CTRL_ONE)
      |=> stopped_ff ##1 (!$past(ce_in) || !running_out);
  endproperty
  a_stop: assert property (p_stop) else $error("timer kept running after carry stop");

  property p_start_high;
    ce_in && ctrl1_ff[mft_pkg::C1_START_HI:mft_pkg::C1_START_LO] == 2'b10 && !pin_lvl
      |=> !running_out;
  endproperty
  a_start_high: assert property (p_start_high) else $error("ran with pin low");

  property p_pin_oe;
    ce_in && ctrl2_ff[mft_pkg::C2_PIN_HI:mft_pkg::C2_PIN_LO] == 2'b00 |=> !timer_pin_oe_out;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin driven while disabled");

  property p_capture;
    ce_in && latch_ev |=> capture_out == $past(accu_ff);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed accumulator");

  property p_irq;
    ce_in && ctrl3_ff[mft_pkg::C3_IRQ_HI:mft_pkg::C3_IRQ_LO] == 3'b100
      |-> ##1 (irq_out == $past(carry_hi));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not tied to high carry");

  property p_minus_one;
    ce_in && step && ctrl3_ff[mft_pkg::C3_LO_M1] && !ctrl3_ff[mft_pkg::C3_SERIAL] && !reload
      && !bus_wr_in |=> accu_ff[7:0] == $past(accu_ff[7:0]) - 8'h01;
  endproperty
  a_minus_one: assert property (p_minus_one) else $error("low byte did not count down");

  property p_reload;
    ce_in && reload && !bus_wr_in && !ctrl3_ff[mft_pkg::C3_SERIAL]
      |=> accu_ff[7:0] == $past(addend_ff[7:0]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");
endmodule

/* sim/mft_pin_model.sv */
// Far-side model of the timer pin and the second serial input line.
// Assumes the bench requests levels just after a rising clock edge.
`timescale 1ns/1ps
module mft_pin_model (
  // Clock and requests
  input wire logic ref_clk_in,
  input wire logic level_req_in,
  input wire logic slow_in,
  // Driven lines
  output logic timer_pin_out,
  output logic serial_two_out
);
  logic [1:0] dly_ff;

  // Slow mode: a lagging external driver, two cycles behind the request
  always_ff @(posedge ref_clk_in) begin
    dly_ff <= {dly_ff[0], level_req_in};
  end

  assign timer_pin_out = slow_in ? dly_ff[1] : level_req_in;
  // Opposite level, so a wrong input choice would be visible
  assign serial_two_out = ~timer_pin_out;
endmodule

/* sim/tb_mft_timer.sv */
// Self-checking bench for the multifunction timer.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/1ps
module tb_mft_timer;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] bus_addr_in = 16'h0000;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic [7:0] bus_wdata_in = 8'h00;
  logic [7:0] bus_rdata_out;
  logic osc_tick_in = 1'b0;
  logic phi_in = 1'b0;
  logic level_req = 1'b0;
  logic slow = 1'b0;
  logic pin_w, ser_w, pin_o, pin_oe, irq_w, run_w;
  logic [15:0] cap_w;
  logic [7:0] rd_v, lo, hi, step;
  logic [1:0] sel, other;
  logic [15:0] wo[9] = '{16'h0236, 16'h0237, 16'h0238, 16'h0239, 16'h023A,
                         16'h023C, 16'h023D, 16'h023B, 16'h0240};
  int num_errors = 0;
  int comparisons = 0;
  int irq_cnt = 0;
  int n;

  always #2 ref_clk_in = ~ref_clk_in;
  // Pulses are one cycle wide, so count them at every edge
  always @(posedge ref_clk_in) if (irq_w === 1'b1) irq_cnt++;

  mft_pin_model PARTNER (.ref_clk_in(ref_clk_in), .level_req_in(level_req), .slow_in(slow),
    .timer_pin_out(pin_w), .serial_two_out(ser_w));

  mft_timer DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .bus_addr_in(bus_addr_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .osc_tick_in(osc_tick_in),
    .processor_phase_two_clock_in(phi_in), .timer_pin_in(pin_w), .serial_in_two_in(ser_w),
    .timer_pin_out(pin_o), .timer_pin_oe_out(pin_oe), .irq_out(irq_w),
    .running_out(run_w), .capture_out(cap_w));

  function automatic logic [15:0] carries(logic [1:0] src, logic [7:0] stp, int cnt);
    return ((src == 2'b01 || src == 2'b10) && (int'(stp) * cnt >= 256)) ? 16'h0001 : 16'h0000;
  endfunction

  function automatic logic [15:0] pin_irq(int m, logic after_fall);
    return (m == 1 || (m == 2 && after_fall)) ? 16'h0001 : 16'h0000;
  endfunction

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr_in = a;
    bus_wdata_in = d;
    bus_wr_in = 1'b1;
    cyc(1);
    bus_wr_in = 1'b0;
    // Idle cycle, so back-to-back writes never retoggle the strobe
    cyc(1);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus_addr_in = a;
    bus_rd_in = 1'b1;
    cyc(1);
    bus_rd_in = 1'b0;
    cyc(1);
    d = bus_rdata_out;
  endtask

  task automatic tick(input logic [1:0] s);
    osc_tick_in = s[0];
    phi_in = s[1];
    cyc(1);
    osc_tick_in = 1'b0;
    phi_in = 1'b0;
    cyc(3);
  endtask

  // Every byte written before counting, no undefined codes
  task automatic setup(input logic [1:0] src, input logic [7:0] stp);
    wr(mft_pkg::ADDR_CTRL_TWO, 8'hC0);
    wr(mft_pkg::ADDR_CTRL_THREE, 8'h60);
    wr(mft_pkg::ADDR_PRESC_LO, 8'h00);
    wr(mft_pkg::ADDR_PRESC_HI, 8'h00);
    wr(mft_pkg::ADDR_ADDEND_LO, stp);
    wr(mft_pkg::ADDR_ADDEND_HI, 8'h00);
    wr(mft_pkg::ADDR_ACCU_LO, 8'h00);
    wr(mft_pkg::ADDR_ACCU_HI, 8'h00);
    wr(mft_pkg::ADDR_CTRL_ONE, {1'b0, src, 5'h10});
  endtask

  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(50));
    repeat (8) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    cyc(1);
    repeat (4) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      wr(mft_pkg::ADDR_ADDEND_HI, hi);
      wr(mft_pkg::ADDR_ADDEND_LO, lo);
      rd(mft_pkg::ADDR_ADDEND_LO, rd_v);
      chk("addend_low", {8'h00, lo}, {8'h00, rd_v});
      rd(mft_pkg::ADDR_ADDEND_HI, rd_v);
      chk("addend_high", {8'h00, hi}, {8'h00, rd_v});
    end
    // Write-only and unmapped places; 5A keeps every field defined
    foreach (wo[i]) begin
      wr(wo[i], 8'h5A);
      rd(wo[i], rd_v);
      chk("write_only_read", 16'h0000, {8'h00, rd_v});
    end
    for (int s = 1; s < 4; s++) begin
      step = 8'h40 << $urandom_range(1);
      n = 256 / int'(step);
      sel = (s == 1) ? 2'b01 : (s == 2) ? 2'b10 : 2'b11;
      other = (s == 1) ? 2'b10 : (s == 2) ? 2'b01 : 2'b00;
      setup(2'(s), step);
      chk("pin_oe_carry", 16'h0001, {15'h0000, pin_oe});
      irq_cnt = 0;
      repeat (n) tick(other);
      repeat (n - 1) tick(sel);
      chk("irq_early", 16'h0000, 16'(irq_cnt));
      tick(sel);
      cyc(4);
      chk("irq_carry", carries(2'(s), step, n), 16'(irq_cnt));
      if (s < 3) begin
        chk("running_stopped", 16'h0000, {15'h0000, run_w});
      end
      repeat (n) tick(sel);
      chk("irq_after_stop", carries(2'(s), step, n), 16'(irq_cnt));
    end
    wr(mft_pkg::ADDR_CTRL_ONE, 8'h60);
    wr(mft_pkg::ADDR_CTRL_TWO, 8'h00);
    cyc(2);
    chk("pin_oe_off", 16'h0000, {15'h0000, pin_oe});
    // Interrupt event codes none, pin and inverted pin
    for (int m = 0; m < 3; m++) begin
      wr(mft_pkg::ADDR_CTRL_THREE, {3'(m), 5'h00});
      slow = 1'($urandom_range(1));
      irq_cnt = 0;
      level_req = 1'b1;
      cyc(12);
      chk("irq_pin_rise", pin_irq(m, 1'b0), 16'(irq_cnt));
      level_req = 1'b0;
      cyc(12);
      chk("irq_pin_fall", pin_irq(m, 1'b1), 16'(irq_cnt));
    end
    // Low byte counts down, capture on prescaler input, PWM on the pin
    lo = 8'h80 | 8'($urandom);
    wr(mft_pkg::ADDR_CTRL_THREE, 8'h84);
    wr(mft_pkg::ADDR_CTRL_TWO, 8'hB0);
    wr(mft_pkg::ADDR_ADDEND_HI, 8'h30);
    wr(mft_pkg::ADDR_ACCU_LO, lo);
    wr(mft_pkg::ADDR_ACCU_HI, 8'h00);
    chk("pwm_pin_high", 16'h0001, {15'h0000, pin_o});
    wr(mft_pkg::ADDR_CTRL_ONE, 8'h20);
    irq_cnt = 0;
    repeat (5) tick(2'b01);
    chk("capture_countdown", {8'hC0, lo - 8'h04}, cap_w);
    chk("pwm_pin_low", 16'h0000, {15'h0000, pin_o});
    chk("irq_no_high_carry", 16'h0000, 16'(irq_cnt));
    wrap_up();
  end
endmodule
